//--- cpu_arith_logic_unit.sv
// Arithmetic, logic and multiply-accumulate datapath of the CPU
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps

module cpu_arith_logic_unit (
   input wire logic clk, // 50 MHz clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic op_valid, // One operation this cycle
   input wire alu_pkg::op_t op_code, // Operation to perform
   input wire alu_pkg::size_t op_size, // Byte, word or longword
   input wire logic op_imm, // Second operand is immediate
   input wire logic [31:0] opa, // Destination register or memory
   input wire logic [31:0] opb, // Source register or immediate
   output logic res_valid, // Result of last operation stands
   output logic res_write, // Result goes back to destination
   output logic [31:0] res_data, // Result, untouched bits kept
   output logic op_error, // Last operation was refused
   output alu_pkg::flags_t flags, // Condition flags
   input wire logic [3:0] reg_addr, // Register byte address
   input wire logic [31:0] reg_wdata, // Register write data
   input wire logic reg_wr, // Register write strobe
   input wire logic reg_rd, // Register read strobe
   output logic [31:0] reg_rdata // Read data, cycle after strobe
);
   import alu_pkg::*;

   typedef struct packed {
      logic [31:0] res_data;
      logic res_valid;
      logic res_write;
      logic err;
      flags_t flags;
      logic [MAC_W-1:0] mac;
      logic sat;
      logic [31:0] rdata;
   } state_t;

   state_t q;
   state_t d;

   logic [31:0] mask;
   int unsigned cpos;
   int unsigned hpos;
   int unsigned spos;
   logic illegal;
   logic add_sub;
   logic add_ci;
   logic [31:0] add_x;
   logic [31:0] add_y;
   logic [31:0] add_y_eff;
   logic [32:0] sum33;
   logic [32:0] cx;
   logic add_c;
   logic add_h;
   logic add_v;
   logic [31:0] add_res;
   logic [31:0] lg_raw;
   logic [31:0] lg_res;
   logic [15:0] mu8;
   logic [31:0] mu16;
   logic signed [15:0] ms8;
   logic signed [31:0] ms16;
   logic [7:0] da_adj;
   logic da_c;
   logic [7:0] da_res;
   logic [MAC_W-1:0] mac_wide;
   logic [32:0] mac_s33;
   logic [31:0] mac_clamp;
   div_if dv ();

   // Divider sits outside; only the shape and signedness are chosen here
   assign dv.dividend = opa;
   assign dv.divisor = opb[15:0];
   assign dv.wide = (op_size == SZ_W);
   assign dv.is_signed = (op_code == OP_DIV_S);

   alu_divider u_div (
      .dv (dv.slave)
   );

   // Size decides mask, carry position and sign position
   always_comb begin
      case (op_size)
         SZ_B: begin
            mask = MASK_B;
            cpos = CARRY_B;
            hpos = HALF_B;
         end
         SZ_W: begin
            mask = MASK_W;
            cpos = CARRY_W;
            hpos = HALF_W;
         end
         default: begin
            mask = MASK_L;
            cpos = CARRY_L;
            hpos = HALF_L;
         end
      endcase
      spos = cpos - 1;
   end

   // Refused forms; the decoder learns of them through op_error
   always_comb begin
      case (op_code)
         OP_SUB: illegal = op_imm && (op_size == SZ_B);
         OP_ADD_CARRY, OP_SUB_BORROW: illegal = (op_size != SZ_B);
         OP_DECIMAL_ADD, OP_DECIMAL_SUB, OP_TEST_SET:
            illegal = (op_size != SZ_B);
         OP_STEP_UP, OP_STEP_DOWN:
            illegal = !((opb == STEP_ONE) ||
                        ((opb == STEP_TWO) && (op_size != SZ_B)));
         OP_LONG_ADD_SMALL, OP_LONG_SUB_SMALL:
            illegal = (op_size != SZ_L) ||
                      !((opb == STEP_ONE) || (opb == STEP_TWO) ||
                        (opb == STEP_FOUR));
         OP_MUL_U, OP_MUL_S, OP_DIV_U, OP_DIV_S:
            illegal = (op_size != SZ_B) && (op_size != SZ_W);
         OP_ZERO_EXT, OP_SIGN_EXT: illegal = (op_size == SZ_B);
         default: illegal = 1'b0;
      endcase
   end

   // One shared adder: subtraction adds the inverted operand plus one, or plus the inverted carry for subtract with borrow
   always_comb begin
      add_x = opa & mask;
      add_y = opb & mask;
      add_sub = 1'b0;
      add_ci = 1'b0;
      case (op_code)
         OP_SUB, OP_COMPARE, OP_STEP_DOWN, OP_LONG_SUB_SMALL: begin
            add_sub = 1'b1;
            add_ci = 1'b1;
         end
         OP_ADD_CARRY: add_ci = q.flags.c;
         OP_SUB_BORROW: begin
            add_sub = 1'b1;
            add_ci = ~q.flags.c;
         end
         OP_NEGATE: begin
            add_x = 32'h00000000;
            add_y = opa & mask;
            add_sub = 1'b1;
            add_ci = 1'b1;
         end
         default: ;
      endcase
   end

   // Carry out of the sized top bit; borrow is its inverse
   assign add_y_eff = add_sub ? (~add_y & mask) : add_y;
   assign sum33 = {1'b0, add_x} + {1'b0, add_y_eff} + {32'h00000000, add_ci};
   assign cx = {1'b0, add_x} ^ {1'b0, add_y_eff} ^ sum33;
   assign add_c = add_sub ? ~cx[cpos] : cx[cpos];
   assign add_h = add_sub ? ~cx[hpos] : cx[hpos];
   assign add_v = (add_x[spos] == add_y_eff[spos]) &&
                  (sum33[spos] != add_x[spos]);
   assign add_res = (opa & ~mask) | (sum33[31:0] & mask);

   // Logic unit, merged into the untouched upper bits
   always_comb begin
      case (op_code)
         OP_AND: lg_raw = opa & opb;
         OP_OR: lg_raw = opa | opb;
         OP_XOR: lg_raw = opa ^ opb;
         default: lg_raw = ~opa;
      endcase
      lg_res = (opa & ~mask) | (lg_raw & mask);
   end

   // Multipliers; the signed 16x16 one also feeds the accumulator
   assign mu8 = opa[7:0] * opb[7:0];
   assign mu16 = opa[15:0] * opb[15:0];
   assign ms8 = $signed(opa[7:0]) * $signed(opb[7:0]);
   assign ms16 = $signed(opa[15:0]) * $signed(opb[15:0]);

   // Decimal adjust after add or subtract, driven by c and h
   always_comb begin
      da_adj = 8'h00;
      da_c = q.flags.c;
      if (op_code == OP_DECIMAL_ADD) begin
         if (q.flags.c || (opa[7:0] > DA_BYTE_MAX)) begin
            da_adj = da_adj | DA_HIGH;
            da_c = 1'b1;
         end
         if (q.flags.h || (opa[3:0] > DA_NIB_MAX)) begin
            da_adj = da_adj | DA_LOW;
         end
         da_res = opa[7:0] + da_adj;
      end else begin
         if (q.flags.c) begin
            da_adj = da_adj | DA_HIGH;
         end
         if (q.flags.h) begin
            da_adj = da_adj | DA_LOW;
         end
         da_res = opa[7:0] - da_adj;
      end
   end

   // Accumulate: wide sum never clips, 32-bit sum clamps at the limits
   assign mac_wide = q.mac + {{(MAC_W-32){ms16[31]}}, ms16};
   assign mac_s33 = {q.mac[31], q.mac[31:0]} + {ms16[31], ms16};
   assign mac_clamp = (mac_s33[32] == mac_s33[31]) ? mac_s33[31:0] :
                      (mac_s33[32] ? SAT_MIN : SAT_MAX);

   // Next state of results, flags, accumulator and register port
   always_comb begin
      d = q;
      d.res_valid = op_valid;
      d.res_write = 1'b0;
      d.err = 1'b0;
      d.rdata = 32'h00000000;
      // Software writes come first so that an operation's flags win
      if (reg_wr) begin
         case (reg_addr)
            REG_CFG: d.sat = reg_wdata[CFG_SAT_BIT];
            REG_FLAGS: d.flags = reg_wdata[4:0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            REG_CFG: d.rdata = {31'h00000000, q.sat};
            REG_FLAGS: d.rdata = {27'h0000000, q.flags};
            REG_MAC_HI: d.rdata = {22'h000000, q.mac[MAC_W-1:32]};
            REG_MAC_LO: d.rdata = q.mac[31:0];
            default: d.rdata = 32'h00000000;
         endcase
      end
      if (op_valid && illegal) begin
         d.err = 1'b1;
      end else if (op_valid) begin
         case (op_code)
            OP_ADD, OP_SUB, OP_ADD_CARRY, OP_SUB_BORROW,
            OP_COMPARE, OP_NEGATE: begin
               d.res_data = add_res;
               d.res_write = (op_code != OP_COMPARE);
               d.flags.h = add_h;
               d.flags.n = sum33[spos];
               d.flags.v = add_v;
               d.flags.c = add_c;
               // Carry chains only clear zero, so multi-byte zero holds
               if ((op_code == OP_ADD_CARRY) || (op_code == OP_SUB_BORROW)) begin
                  d.flags.z = q.flags.z && ((sum33[31:0] & mask) == 32'h0);
               end else begin
                  d.flags.z = ((sum33[31:0] & mask) == 32'h0);
               end
            end
            OP_STEP_UP, OP_STEP_DOWN: begin
               d.res_data = add_res;
               d.res_write = 1'b1;
               d.flags.n = sum33[spos];
               d.flags.z = ((sum33[31:0] & mask) == 32'h0);
               d.flags.v = add_v;
            end
            OP_LONG_ADD_SMALL, OP_LONG_SUB_SMALL: begin
               d.res_data = add_res;
               d.res_write = 1'b1;
            end
            OP_DECIMAL_ADD, OP_DECIMAL_SUB: begin
               d.res_data = {opa[31:8], da_res};
               d.res_write = 1'b1;
               d.flags.n = da_res[7];
               d.flags.z = (da_res == 8'h00);
               d.flags.v = 1'b0;
               d.flags.c = da_c;
            end
            OP_MUL_U: begin
               d.res_data = (op_size == SZ_B) ? {opa[31:16], mu8} : mu16;
               d.res_write = 1'b1;
            end
            OP_MUL_S: begin
               d.res_data = (op_size == SZ_B) ? {opa[31:16], ms8} : ms16;
               d.res_write = 1'b1;
               d.flags.n = (op_size == SZ_B) ? ms8[15] : ms16[31];
               d.flags.z = (op_size == SZ_B) ? (ms8 == 16'sh0000) :
                                              (ms16 == 32'sh00000000);
            end
            OP_DIV_U, OP_DIV_S: begin
               // Zero divisor: nothing written, zero flag raised
               d.flags.z = dv.div_zero;
               if (!dv.div_zero) begin
                  d.res_write = 1'b1;
                  if (op_size == SZ_B) begin
                     d.res_data = {opa[31:16], dv.remainder[7:0],
                                   dv.quotient[7:0]};
                     d.flags.n = dv.quotient[7];
                  end else begin
                     d.res_data = {dv.remainder, dv.quotient};
                     d.flags.n = dv.quotient[15];
                  end
               end
            end
            OP_ZERO_EXT, OP_SIGN_EXT: begin
               if (op_size == SZ_W) begin
                  d.res_data = {opa[31:16],
                     {8{(op_code == OP_SIGN_EXT) & opa[7]}}, opa[7:0]};
                  d.flags.n = (op_code == OP_SIGN_EXT) & opa[7];
                  d.flags.z = (opa[7:0] == 8'h00);
               end else begin
                  d.res_data = {{16{(op_code == OP_SIGN_EXT) & opa[15]}},
                                opa[15:0]};
                  d.flags.n = (op_code == OP_SIGN_EXT) & opa[15];
                  d.flags.z = (opa[15:0] == 16'h0000);
               end
               d.res_write = 1'b1;
               d.flags.v = 1'b0;
            end
            OP_TEST_SET: begin
               d.res_data = {opa[31:8], opa[7:0] | TAS_SET};
               d.res_write = 1'b1;
               d.flags.n = opa[7];
               d.flags.z = (opa[7:0] == 8'h00);
               d.flags.v = 1'b0;
            end
            OP_MAC: begin
               if (q.sat) begin
                  d.mac = {{(MAC_W-32){mac_clamp[31]}}, mac_clamp};
               end else begin
                  d.mac = mac_wide;
               end
            end
            OP_ACC_CLEAR: d.mac = {MAC_W{1'b0}};
            OP_ACC_LOAD_HI: d.mac[MAC_W-1:32] = opb[MAC_W-33:0];
            OP_ACC_LOAD_LO: d.mac[31:0] = opb;
            OP_ACC_STORE_HI: begin
               d.res_data = {{(64-MAC_W){q.mac[MAC_W-1]}}, q.mac[MAC_W-1:32]};
               d.res_write = 1'b1;
            end
            OP_ACC_STORE_LO: begin
               d.res_data = q.mac[31:0];
               d.res_write = 1'b1;
            end
            default: begin
               d.res_data = lg_res;
               d.res_write = 1'b1;
               d.flags.n = lg_res[spos];
               d.flags.z = ((lg_res & mask) == 32'h0);
               d.flags.v = 1'b0;
            end
         endcase
      end
   end

   // Single state register; reset clears results and the accumulator
   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
         q.flags <= FLAGS_RST;
         q.sat <= CFG_SAT_RST;
      end else begin
         q <= d;
      end
   end

   // Outputs come straight from the state register
   assign res_valid = q.res_valid;
   assign res_write = q.res_write;
   assign res_data = q.res_data;
   assign op_error = q.err;
   assign flags = q.flags;
   assign reg_rdata = q.rdata;

   // Helper copies so that past values can be taken of whole signals
   logic [15:0] opa16;
   logic [15:0] opb16;
   assign opa16 = opa[15:0];
   assign opb16 = opb[15:0];

   a_compare_no_write: assert property (@(posedge clk) disable iff (rst)
      op_valid && (op_code == OP_COMPARE) |=> res_valid && !res_write)
      else $error("compare wrote its destination");

   a_sub_imm_byte: assert property (@(posedge clk) disable iff (rst)
      op_valid && (op_code == OP_SUB) && op_imm && (op_size == SZ_B)
      |=> op_error && !res_write)
      else $error("byte immediate subtract was accepted");

   a_carry_add_size: assert property (@(posedge clk) disable iff (rst)
      op_valid && (op_code == OP_ADD_CARRY) && (op_size != SZ_B)
      |=> op_error && !res_write && $stable(flags))
      else $error("wide carry add was accepted");

   a_step_byte_two: assert property (@(posedge clk) disable iff (rst)
      op_valid && (op_code == OP_STEP_UP) && (op_size == SZ_B) &&
      (opb == STEP_TWO) |=> op_error && $stable(flags))
      else $error("byte stepped by two");

   a_test_set_msb: assert property (@(posedge clk) disable iff (rst)
      op_valid && (op_code == OP_TEST_SET) && (op_size == SZ_B)
      |=> res_write && res_data[7] && (flags.n == $past(opa[7])))
      else $error("test and set lost bit 7 or flag");

   a_negate_long: assert property (@(posedge clk) disable iff (rst)
      op_valid && (op_code == OP_NEGATE) && (op_size == SZ_L)
      |=> res_write && (res_data == 32'h00000000 - $past(opa)))
      else $error("negate result wrong");

   a_mul_u_word: assert property (@(posedge clk) disable iff (rst)
      op_valid && (op_code == OP_MUL_U) && (op_size == SZ_W)
      |=> res_data == ({16'h0000, $past(opa16)} * {16'h0000, $past(opb16)}))
      else $error("unsigned word product wrong");

   a_acc_clear: assert property (@(posedge clk) disable iff (rst)
      op_valid && (op_code == OP_ACC_CLEAR) |=> (q.mac == {MAC_W{1'b0}}))
      else $error("accumulator not cleared");

   a_sat_range: assert property (@(posedge clk) disable iff (rst)
      op_valid && (op_code == OP_MAC) && q.sat
      |=> (q.mac[MAC_W-1:31] == {(MAC_W-31){q.mac[31]}}))
      else $error("saturating accumulate left 32-bit range");

   a_and_zero_flag: assert property (@(posedge clk) disable iff (rst)
      op_valid && (op_code == OP_AND) && (op_size == SZ_B) && !illegal
      |=> (flags.z == (res_data[7:0] == 8'h00)) && !flags.v)
      else $error("zero flag does not match logic result");

endmodule // cpu_arith_logic_unit

//--- alu_pkg.sv
// Shared constants and types for the arithmetic and logic datapath
package alu_pkg;

   // Operand masks and carry, half-carry bit positions per size
   localparam logic [31:0] MASK_B = 32'h000000FF;
   localparam logic [31:0] MASK_W = 32'h0000FFFF;
   localparam logic [31:0] MASK_L = 32'hFFFFFFFF;
   localparam int unsigned CARRY_B = 8;
   localparam int unsigned CARRY_W = 16;
   localparam int unsigned CARRY_L = 32;
   localparam int unsigned HALF_B = 4;
   localparam int unsigned HALF_W = 12;
   localparam int unsigned HALF_L = 28;

   // Step sizes for step and long small-constant operations
   localparam logic [31:0] STEP_ONE = 32'h00000001;
   localparam logic [31:0] STEP_TWO = 32'h00000002;
   localparam logic [31:0] STEP_FOUR = 32'h00000004;

   // Decimal adjust constants
   localparam logic [7:0] DA_LOW = 8'h06;
   localparam logic [7:0] DA_HIGH = 8'h60;
   localparam logic [7:0] DA_BYTE_MAX = 8'h99;
   localparam logic [3:0] DA_NIB_MAX = 4'h9;

   // Test-and-set forces the top bit of the byte
   localparam logic [7:0] TAS_SET = 8'h80;

   // Accumulator widths and saturation limits
   localparam int unsigned MAC_W = 42;
   localparam logic [31:0] SAT_MAX = 32'h7FFFFFFF;
   localparam logic [31:0] SAT_MIN = 32'h80000000;

   // Register map, byte addresses on the plain register port
   localparam logic [3:0] REG_CFG = 4'h0;
   localparam logic [3:0] REG_FLAGS = 4'h4;
   localparam logic [3:0] REG_MAC_HI = 4'h8;
   localparam logic [3:0] REG_MAC_LO = 4'hC;
   localparam int unsigned CFG_SAT_BIT = 0;
   localparam logic CFG_SAT_RST = 1'b0;

   typedef enum logic [1:0] {SZ_B, SZ_W, SZ_L} size_t;

   typedef enum logic [4:0] {
      OP_ADD, OP_SUB, OP_ADD_CARRY, OP_SUB_BORROW, OP_STEP_UP, OP_STEP_DOWN,
      OP_LONG_ADD_SMALL, OP_LONG_SUB_SMALL, OP_DECIMAL_ADD, OP_DECIMAL_SUB,
      OP_MUL_U, OP_MUL_S, OP_DIV_U, OP_DIV_S, OP_COMPARE, OP_NEGATE,
      OP_ZERO_EXT, OP_SIGN_EXT, OP_TEST_SET, OP_MAC, OP_ACC_CLEAR,
      OP_ACC_LOAD_HI, OP_ACC_LOAD_LO, OP_ACC_STORE_HI, OP_ACC_STORE_LO,
      OP_AND, OP_OR, OP_XOR, OP_NOT
   } op_t;

   // Condition flags, c in bit 0 up to h in bit 4
   typedef struct packed {
      logic h;
      logic n;
      logic z;
      logic v;
      logic c;
   } flags_t;

   localparam flags_t FLAGS_RST = 5'h00;

endpackage

//--- div_if.sv
// Carrier between the datapath and its divider
`timescale 1ns/1ps
interface div_if;
   logic [31:0] dividend;
   logic [15:0] divisor;
   logic is_signed;
   logic wide;
   logic [15:0] quotient;
   logic [15:0] remainder;
   logic div_zero;
   modport master (output dividend, divisor, is_signed, wide,
                   input quotient, remainder, div_zero);
   modport slave (input dividend, divisor, is_signed, wide,
                  output quotient, remainder, div_zero);
endinterface

//--- alu_divider.sv
// Combinational 16/8 and 32/16 divider, signed or unsigned
`timescale 1ns/1ps
module alu_divider (
   div_if.slave dv // Operands in, quotient and remainder out
);
   import alu_pkg::*;

   logic [31:0] dd_ext;
   logic [15:0] dv_ext;
   logic dd_neg;
   logic dv_neg;
   logic [31:0] dd_mag;
   logic [15:0] dv_mag;
   logic [15:0] dv_safe;
   logic [31:0] q_mag;
   logic [31:0] r_mag;
   logic [31:0] q_sgn;
   logic [31:0] r_sgn;

   // Work on magnitudes; quotient sign from both, remainder from dividend
   always_comb begin
      if (dv.wide) begin
         dd_ext = dv.dividend;
         dv_ext = dv.divisor;
      end else begin
         dd_ext = {{16{dv.is_signed & dv.dividend[15]}}, dv.dividend[15:0]};
         dv_ext = {{8{dv.is_signed & dv.divisor[7]}}, dv.divisor[7:0]};
      end
      dd_neg = dv.is_signed & dd_ext[31];
      dv_neg = dv.is_signed & dv_ext[15];
      dd_mag = dd_neg ? (~dd_ext + 32'h00000001) : dd_ext;
      dv_mag = dv_neg ? (~dv_ext + 16'h0001) : dv_ext;
      dv.div_zero = (dv_mag == 16'h0000);
      // Guarded divisor keeps the operators free of unknowns
      dv_safe = dv.div_zero ? 16'h0001 : dv_mag;
      q_mag = dd_mag / {16'h0000, dv_safe};
      r_mag = dd_mag % {16'h0000, dv_safe};
      q_sgn = (dd_neg ^ dv_neg) ? (~q_mag + 32'h00000001) : q_mag;
      r_sgn = dd_neg ? (~r_mag + 32'h00000001) : r_mag;
      dv.quotient = q_sgn[15:0];
      dv.remainder = r_sgn[15:0];
   end

endmodule // alu_divider

//--- wb_model.sv
// Write-back model of the destination register behind the datapath
`timescale 1ns/1ps
module wb_model (
   input wire logic clk, // Shared clock
   input wire logic rst, // Synchronous reset
   input wire logic res_valid, // Result stands
   input wire logic res_write, // Result to be written
   input wire logic [31:0] res_data, // Result value
   output logic [31:0] dest_q // Destination register copy
);
   // Refused ops must leave the register alone, so latch on write only
   always_ff @(posedge clk) begin
      if (rst) begin
         dest_q <= 32'h0;
      end else if (res_valid && res_write) begin
         dest_q <= res_data;
      end
   end
endmodule // wb_model

//--- tb.sv
// Self-checking bench for the arithmetic and logic datapath
`timescale 1ns/1ps
module tb;
   import alu_pkg::*;
   localparam logic [2:0] WR = 3'b010, ER = 3'b001, NW = 3'b000;
   localparam logic [2:0] SK = 3'b011, IE = 3'b101;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic op_valid = 1'b0, op_imm = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   op_t op_code = OP_ADD;
   size_t op_size = SZ_B;
   logic [31:0] opa = 32'h0, opb = 32'h0, reg_wdata = 32'h0;
   logic [3:0] reg_addr = 4'h0;
   logic res_valid, res_write, op_error;
   logic [31:0] res_data, reg_rdata, dest_q;
   flags_t flags;
   int error_cnt = 0;
   int comparisons = 0;
   int cycles = 0;

   cpu_arith_logic_unit dut (.clk(clk), .rst(rst), .op_valid(op_valid),
      .op_code(op_code), .op_size(op_size), .op_imm(op_imm), .opa(opa),
      .opb(opb), .res_valid(res_valid), .res_write(res_write),
      .res_data(res_data), .op_error(op_error), .flags(flags),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   wb_model rf (.clk(clk), .rst(rst), .res_valid(res_valid),
      .res_write(res_write), .res_data(res_data), .dest_q(dest_q));

   // 50 MHz clock
   always #10 clk = ~clk;

   // Hang guard, well above the some 124 cycles the tests need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         error_cnt++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk_data(input string n, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_flags(input flags_t e);
      comparisons++;
      if (flags !== e) begin
         error_cnt++;
         $display("[FAIL] flags expected %h seen %h", e, flags);
      end
   endtask

   // One op; m is {immediate, write expected, refusal expected}
   task automatic run_op(input op_t c, input size_t s,
      input logic [31:0] a, b, d, input logic [2:0] m);
      @(posedge clk);
      op_valid <= 1'b1;
      op_code <= c;
      op_size <= s;
      op_imm <= m[2];
      opa <= a;
      opb <= b;
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
      chk_data("res_valid", 32'h1, {31'h0, res_valid});
      if (m[1:0] != 2'b11) begin
         chk_data("op_error", {31'h0, m[0]}, {31'h0, op_error});
         chk_data("res_write", {31'h0, m[1]}, {31'h0, res_write});
         if (m[1]) chk_data("res_data", d, res_data);
      end
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk_data("reg_rdata", e, reg_rdata);
   endtask

   // Main sequence; expected values worked out by hand
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      reg_read(REG_CFG, 32'h0);
      reg_read(4'h2, 32'h0);
      reg_write(REG_FLAGS, 32'h1F);
      reg_read(REG_FLAGS, 32'h1F);
      run_op(OP_ADD, SZ_B, 32'h1122337F, 32'h1, 32'h11223380, WR);
      chk_flags(5'h1A);
      run_op(OP_ADD, SZ_B, 32'hFF, 32'h1, 32'h0, WR);
      chk_flags(5'h15);
      run_op(OP_ADD_CARRY, SZ_B, 32'h10, 32'h1, 32'h12, WR);
      run_op(OP_ADD_CARRY, SZ_W, 32'h10, 32'h1, 32'h0, ER);
      run_op(OP_SUB, SZ_L, 32'h0, 32'h1, 32'hFFFFFFFF, WR);
      run_op(OP_SUB_BORROW, SZ_B, 32'h10, 32'h1, 32'hE, WR);
      run_op(OP_COMPARE, SZ_W, 32'h1234, 32'h1234, 32'h0, NW);
      chk_flags(5'h04);
      run_op(OP_SUB, SZ_B, 32'h10, 32'h1, 32'h0, IE);
      chk_flags(5'h04);
      run_op(OP_SUB, SZ_B, 32'h10, 32'h1, 32'hF, WR);
      run_op(OP_STEP_UP, SZ_B, 32'h10, 32'h2, 32'h0, ER);
      run_op(OP_STEP_DOWN, SZ_W, 32'hABCD0000, 32'h2, 32'hABCDFFFE, WR);
      run_op(OP_LONG_ADD_SMALL, SZ_L, 32'hFFFFFFFE, 32'h4, 32'h2, WR);
      run_op(OP_LONG_SUB_SMALL, SZ_L, 32'h8, 32'h3, 32'h0, ER);
      run_op(OP_ADD, SZ_B, 32'h15, 32'h27, 32'h3C, WR);
      run_op(OP_DECIMAL_ADD, SZ_B, 32'h3C, 32'h0, 32'h42, WR);
      run_op(OP_MUL_U, SZ_B, 32'hFF, 32'hFF, 32'hFE01, WR);
      run_op(OP_MUL_S, SZ_B, 32'hFF, 32'h2, 32'hFFFE, WR);
      run_op(OP_MUL_S, SZ_L, 32'hFF, 32'h2, 32'h0, ER);
      run_op(OP_DIV_U, SZ_B, 32'h7, 32'h2, 32'h103, WR);
      run_op(OP_DIV_S, SZ_B, 32'hFFF9, 32'h2, 32'hFFFD, WR);
      run_op(OP_DIV_U, SZ_B, 32'h7, 32'h0, 32'h0, NW);
      run_op(OP_NEGATE, SZ_B, 32'h1, 32'h0, 32'hFF, WR);
      run_op(OP_ZERO_EXT, SZ_W, 32'h1280, 32'h0, 32'h80, WR);
      run_op(OP_SIGN_EXT, SZ_L, 32'h8000, 32'h0, 32'hFFFF8000, WR);
      run_op(OP_SIGN_EXT, SZ_B, 32'h80, 32'h0, 32'h0, ER);
      run_op(OP_TEST_SET, SZ_B, 32'h0, 32'h0, 32'h80, WR);
      run_op(OP_AND, SZ_W, 32'h1234F0F0, 32'hFF00, 32'h1234F000, WR);
      run_op(OP_OR, SZ_B, 32'hF, 32'hF0, 32'hFF, WR);
      run_op(OP_XOR, SZ_L, 32'hFFFF0000, 32'hF0F0F0F, 32'hF0F00F0F, WR);
      run_op(OP_NOT, SZ_B, 32'h5A, 32'h0, 32'hA5, WR);
      run_op(OP_MUL_U, SZ_W, 32'hFFFF, 32'hFFFF, 32'hFFFE0001, WR);
      run_op(OP_NEGATE, SZ_L, 32'h1, 32'h0, 32'hFFFFFFFF, WR);
      run_op(OP_AND, SZ_B, 32'h1234F0F0, 32'hF, 32'h1234F000, WR);
      chk_flags(5'h15);
      run_op(OP_DIV_U, SZ_W, 32'h10005, 32'h10, 32'h51000, WR);
      run_op(OP_DIV_S, SZ_W, 32'hFFFFFFF9, 32'h2, 32'hFFFFFFFD, WR);
      run_op(OP_SUB, SZ_B, 32'h42, 32'h15, 32'h2D, WR);
      run_op(OP_DECIMAL_SUB, SZ_B, 32'h2D, 32'h0, 32'h27, WR);
      run_op(OP_ACC_CLEAR, SZ_L, 32'h0, 32'h0, 32'h0, SK);
      run_op(OP_MAC, SZ_L, 32'h3, 32'hFFFE, 32'h0, SK);
      run_op(OP_ACC_STORE_LO, SZ_L, 32'h0, 32'h0, 32'hFFFFFFFA, WR);
      run_op(OP_ACC_STORE_HI, SZ_L, 32'h0, 32'h0, 32'hFFFFFFFF, WR);
      reg_write(REG_MAC_HI, 32'h0);
      reg_read(REG_MAC_HI, 32'h3FF);
      reg_write(REG_CFG, 32'h1);
      reg_read(REG_CFG, 32'h1);
      run_op(OP_ACC_LOAD_LO, SZ_L, 32'h0, 32'h7FFFFFFF, 32'h0, SK);
      run_op(OP_ACC_LOAD_HI, SZ_L, 32'h0, 32'h0, 32'h0, SK);
      run_op(OP_MAC, SZ_L, 32'h1, 32'h1, 32'h0, SK);
      run_op(OP_ACC_STORE_LO, SZ_L, 32'h0, 32'h0, 32'h7FFFFFFF, WR);
      reg_write(REG_CFG, 32'h0);
      run_op(OP_ACC_LOAD_LO, SZ_L, 32'h0, 32'hFFFFFFFF, 32'h0, SK);
      run_op(OP_MAC, SZ_L, 32'h1, 32'h1, 32'h0, SK);
      run_op(OP_ACC_STORE_HI, SZ_L, 32'h0, 32'h0, 32'h1, WR);
      run_op(OP_ACC_CLEAR, SZ_L, 32'h0, 32'h0, 32'h0, SK);
      run_op(OP_ACC_STORE_LO, SZ_L, 32'h5, 32'h0, 32'h0, WR);
      @(posedge clk);
      #1;
      chk_data("dest_q", 32'h0, dest_q);
      end_of_test();
   end
endmodule // tb
